// ---- hdl/ptt_pkg.sv ----
// Constants shared by the periodic tick timer: divider taps, register map,
// field positions, reset values and the bus handshake states.
// Assumes a single 100 MHz clock domain and a 32-bit APB register port.
package ptt_pkg;

	// ----------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------
	localparam int         DIV_W   = 23;
	localparam int         RATE_N  = 8;
	localparam int         RATE_W  = 3;
	// Bit of the divider whose rising edge marks clock/2^(bit+1)
	localparam logic [4:0] TAP_BIT [RATE_N] = '{5'h16, 5'h14, 5'h0F, 5'h0D,
	                                           5'h0C, 5'h0B, 5'h0A, 5'h08};

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W   = 12;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_MASK = 12'h008;
	localparam logic [11:0] OFS_TCNT = 12'h00C;
	localparam logic [11:0] OFS_DIV  = 12'h010;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_EN_BIT   = 3;
	localparam int          CTRL_RATE_LSB = 0;
	localparam logic        CTRL_EN_RST   = 1'h0;
	localparam logic [2:0]  CTRL_RATE_RST = 3'h0;
	localparam int          STAT_W        = 2;
	localparam int          STAT_TICK_BIT = 0;
	localparam int          STAT_OVR_BIT  = 1;
	localparam logic [1:0]  STAT_RST      = 2'h0;
	localparam logic [1:0]  MASK_RST      = 2'h0;
	localparam int          TCNT_W        = 16;
	localparam logic [15:0] TCNT_RST      = 16'h0000;

	// ----------------------------------------------------------------
	// Bus handshake states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RESP = 1'b1
	} ptt_apb_e;

endpackage

// ---- hdl/ptt_divider.sv ----
// Free-running divider of the timing generator with one rising-edge
// pulse per tap. Runs from reset only; software can never clear it.
// Assumes CLK is the main oscillator clock.
`timescale 1ns/10ps

module ptt_divider (
	input  wire logic                       CLK,
	input  wire logic                       RST,
	output logic [ptt_pkg::DIV_W-1:0]       cnt_q,
	output logic [ptt_pkg::RATE_N-1:0]      rise_q
);
	logic [ptt_pkg::DIV_W-1:0]  cnt_ff;
	logic [ptt_pkg::DIV_W-1:0]  nxt_cnt;
	logic [ptt_pkg::RATE_N-1:0] rise_ff;
	logic [ptt_pkg::RATE_N-1:0] nxt_rise;

	// Counter wraps freely; no reset path except RST
	assign nxt_cnt = cnt_ff + {{(ptt_pkg::DIV_W-1){1'b0}}, 1'b1};

	// A tap rises when its bit is one and all lower bits are zero;
	// decoding the value keeps the pulse free of rate-switch artefacts
	for (genvar i = 0; i < ptt_pkg::RATE_N; i++) begin : g_tap
		localparam logic [ptt_pkg::DIV_W-1:0] VAL =
			{{(ptt_pkg::DIV_W-1){1'b0}}, 1'b1} << ptt_pkg::TAP_BIT[i];
		localparam logic [ptt_pkg::DIV_W-1:0] MSK = (VAL << 1) - 1'b1;
		assign nxt_rise[i] = (cnt_ff & MSK) == VAL;
	end

	// Divider and edge registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_ff  <= '0;
			rise_ff <= '0;
		end else begin
			cnt_ff  <= nxt_cnt;
			rise_ff <= nxt_rise;
		end
	end

	assign cnt_q  = cnt_ff;
	assign rise_q = rise_ff;
endmodule

// ---- hdl/ptt_tick_gen.sv ----
// Picks the selected divider tap and issues one tick per rising edge
// while enabled. Assumes rise pulses last a single cycle.
`timescale 1ns/10ps

module ptt_tick_gen (
	input  wire logic                       CLK,
	input  wire logic                       RST,
	input  wire logic [ptt_pkg::RATE_N-1:0] rise,
	input  wire logic [ptt_pkg::RATE_W-1:0] rate,
	input  wire logic                       enable,
	output logic                            tick_q
);
	logic tick_ff;
	logic nxt_tick;

	// Selected edge gated by the enable; the first edge after enabling
	// counts, even if the divider was mid-period
	assign nxt_tick = enable & rise[rate];

	// Tick register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= nxt_tick;
		end
	end

	assign tick_q = tick_ff;
endmodule

// ---- hdl/ptt_top.sv ----
// Periodic tick timer: APB slave, control and interrupt registers,
// divider and tick generator.
// Assumes one clock CLK (100 MHz, also the divider source), an
// asynchronous active-high RST, and an APB master on the same clock.
`timescale 1ns/10ps

// Operation
// - Raise a tick interrupt on each selected divider edge while enabled.
// - First tick comes on the first selected rising edge after enabling.
// - Enabling never clears the shared divider, so first tick may be early.
// - A write disabling a running timer keeps the old rate.
// - A write enabling the timer also loads the new rate.
// - Rate codes 0..7 pick clock over 2^23,21,16,14,13,12,11,9.
// - Control: enable in bit 3, rate in bits 2..0, bits 7..4 zero.
module ptt_top (
	input  wire logic                       CLK,
	input  wire logic                       RST,
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [ptt_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [31:0]                PWDATA,
	input  wire logic [3:0]                 PSTRB,
	output logic [31:0]                     PRDATA,
	output logic                            PREADY,
	output logic                            PSLVERR,
	output logic                            IRQ
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ptt_pkg::ptt_apb_e                st_ff;
	ptt_pkg::ptt_apb_e                nxt_st;
	logic [31:0]                      prdata_ff;
	logic [31:0]                      nxt_prdata;
	logic                             pready_ff;
	logic                             pslverr_ff;
	logic                             nxt_pslverr;
	logic                             irq_ff;
	logic                             en_ff;
	logic                             nxt_en;
	logic [ptt_pkg::RATE_W-1:0]       rate_ff;
	logic [ptt_pkg::RATE_W-1:0]       nxt_rate;
	logic [ptt_pkg::STAT_W-1:0]       stat_ff;
	logic [ptt_pkg::STAT_W-1:0]       nxt_stat;
	logic [ptt_pkg::STAT_W-1:0]       mask_ff;
	logic [ptt_pkg::STAT_W-1:0]       nxt_mask;
	logic [ptt_pkg::TCNT_W-1:0]       tcnt_ff;
	logic [ptt_pkg::TCNT_W-1:0]       nxt_tcnt;
	logic [ptt_pkg::DIV_W-1:0]        div_cnt;
	logic [ptt_pkg::RATE_N-1:0]       div_rise;
	logic                             tick;
	logic                             req;
	logic                             acc;
	logic                             wr;
	logic                             lane0;
	logic                             sel_ctrl;
	logic                             sel_stat;
	logic                             sel_mask;
	logic                             sel_tcnt;
	logic                             sel_div;
	logic                             sel_any;
	logic                             wr_ctrl;
	logic                             wr_stat;
	logic                             wr_mask;
	logic [7:0]                       ctrl_rd;
	logic [ptt_pkg::STAT_W-1:0]       ev;
	logic [ptt_pkg::STAT_W-1:0]       w1c;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	// Divider is shared and free-running; only RST clears it
	ptt_divider u_div (
		.CLK    (CLK),
		.RST    (RST),
		.cnt_q  (div_cnt),
		.rise_q (div_rise)
	);

	ptt_tick_gen u_tick (
		.CLK    (CLK),
		.RST    (RST),
		.rise   (div_rise),
		.rate   (rate_ff),
		.enable (en_ff),
		.tick_q (tick)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Request seen in the access phase; the write lands one cycle later,
	// on the edge where PREADY is high
	assign req      = PSEL & PENABLE & (st_ff == ptt_pkg::ST_IDLE);
	assign acc      = PSEL & PENABLE & (st_ff == ptt_pkg::ST_RESP);
	assign wr       = acc & PWRITE;
	assign lane0    = PSTRB[0];
	assign sel_ctrl = PADDR == ptt_pkg::OFS_CTRL;
	assign sel_stat = PADDR == ptt_pkg::OFS_STAT;
	assign sel_mask = PADDR == ptt_pkg::OFS_MASK;
	assign sel_tcnt = PADDR == ptt_pkg::OFS_TCNT;
	assign sel_div  = PADDR == ptt_pkg::OFS_DIV;
	assign sel_any  = sel_ctrl | sel_stat | sel_mask | sel_tcnt | sel_div;
	assign wr_ctrl  = wr & sel_ctrl & lane0;
	assign wr_stat  = wr & sel_stat & lane0;
	assign wr_mask  = wr & sel_mask & lane0;

	// Handshake: one wait cycle, then PREADY for a single cycle
	always_comb begin
		case (st_ff)
			ptt_pkg::ST_IDLE: begin
				nxt_st = req ? ptt_pkg::ST_RESP : ptt_pkg::ST_IDLE;
			end
			ptt_pkg::ST_RESP: begin
				nxt_st = ptt_pkg::ST_IDLE;
			end
			default: begin
				nxt_st = ptt_pkg::ST_IDLE;
			end
		endcase
	end

	// Unmapped addresses and writes to read-only words answer with an error
	assign nxt_pslverr = req & (~sel_any | (PWRITE & (sel_tcnt | sel_div)));

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Upper nibble always reads zero; writes there are dropped
	assign ctrl_rd = {4'h0, en_ff, rate_ff};

	assign nxt_en = wr_ctrl ? PWDATA[ptt_pkg::CTRL_EN_BIT] : en_ff;

	// Rate loads only from the disabled state: an enabling write takes
	// both fields, a disabling write keeps the running rate
	assign nxt_rate = (wr_ctrl && !en_ff) ?
		PWDATA[ptt_pkg::CTRL_RATE_LSB +: ptt_pkg::RATE_W] : rate_ff;

	// ----------------------------------------------------------------
	// Status, mask and tick counter
	// ----------------------------------------------------------------
	// Overrun marks a tick arriving while the previous one is unserved
	assign ev[ptt_pkg::STAT_TICK_BIT] = tick;
	assign ev[ptt_pkg::STAT_OVR_BIT]  = tick & stat_ff[ptt_pkg::STAT_TICK_BIT];
	assign w1c      = wr_stat ? PWDATA[ptt_pkg::STAT_W-1:0] : '0;
	// Set beats clear so no tick is lost in the clearing cycle
	assign nxt_stat = (stat_ff & ~w1c) | ev;
	assign nxt_mask = wr_mask ? PWDATA[ptt_pkg::STAT_W-1:0] : mask_ff;
	assign nxt_tcnt = tick ? tcnt_ff + 16'h0001 : tcnt_ff;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Data is fetched in the wait cycle so PRDATA leaves a flip-flop
	assign nxt_prdata =
		!(req && !PWRITE) ? prdata_ff :
		sel_ctrl ? {24'h000000, ctrl_rd} :
		sel_stat ? {30'h00000000, stat_ff} :
		sel_mask ? {30'h00000000, mask_ff} :
		sel_tcnt ? {16'h0000, tcnt_ff} :
		sel_div  ? {9'h000, div_cnt} : 32'h00000000;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Bus handshake registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_ff      <= ptt_pkg::ST_IDLE;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			st_ff      <= nxt_st;
			pready_ff  <= req;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	// Software-visible state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			en_ff   <= ptt_pkg::CTRL_EN_RST;
			rate_ff <= ptt_pkg::CTRL_RATE_RST;
			stat_ff <= ptt_pkg::STAT_RST;
			mask_ff <= ptt_pkg::MASK_RST;
			tcnt_ff <= ptt_pkg::TCNT_RST;
		end else begin
			en_ff   <= nxt_en;
			rate_ff <= nxt_rate;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			tcnt_ff <= nxt_tcnt;
		end
	end

	// Level interrupt, one cycle behind the status it reflects
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	assign PRDATA  = prdata_ff;
	assign PREADY  = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign IRQ     = irq_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_enable_write;
		wr_ctrl && !en_ff && PWDATA[ptt_pkg::CTRL_EN_BIT];
	endsequence

	sequence s_disable_write;
		wr_ctrl && en_ff && !PWDATA[ptt_pkg::CTRL_EN_BIT];
	endsequence

	property p_tick_on_edge;
		en_ff && div_rise[rate_ff] |=> tick;
	endproperty
	a_tick_on_edge: assert property (p_tick_on_edge)
		else $error("selected edge while enabled gave no tick");

	property p_tick_needs_enable;
		tick |-> $past(en_ff) && $past(div_rise[rate_ff]);
	endproperty
	a_tick_needs_enable: assert property (p_tick_needs_enable)
		else $error("tick without enable or selected edge");

	property p_enable_loads;
		s_enable_write |=> en_ff && rate_ff == $past(PWDATA[2:0]);
	endproperty
	a_enable_loads: assert property (p_enable_loads)
		else $error("enabling write did not load rate and enable");

	property p_disable_keeps;
		s_disable_write |=> !en_ff && $stable(rate_ff);
	endproperty
	a_disable_keeps: assert property (p_disable_keeps)
		else $error("disabling write changed the rate");

	property p_div_free;
		wr_ctrl |=> div_cnt == $past(div_cnt) + 23'h000001;
	endproperty
	a_div_free: assert property (p_div_free)
		else $error("divider disturbed by a control write");

	property p_tick_phase;
		tick |-> (div_cnt & ((23'h000002 << ptt_pkg::TAP_BIT[$past(rate_ff)]) - 23'h000001))
			== ((23'h000001 << ptt_pkg::TAP_BIT[$past(rate_ff)]) + 23'h000002);
	endproperty
	a_tick_phase: assert property (p_tick_phase)
		else $error("tick not aligned to the selected tap edge");

	property p_ctrl_read;
		req && !PWRITE && sel_ctrl |=> PRDATA[31:4] == 28'h0000000
			&& PRDATA[3] == $past(en_ff);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("control read shows wrong bits");

	property p_first_tick;
		s_enable_write ##1 div_rise[rate_ff] |=> tick;
	endproperty
	a_first_tick: assert property (p_first_tick)
		else $error("first edge after enabling gave no tick");

	property p_set_wins;
		tick && wr_stat && PWDATA[ptt_pkg::STAT_TICK_BIT] |=>
			stat_ff[ptt_pkg::STAT_TICK_BIT] ##1 irq_ff == mask_ff[ptt_pkg::STAT_TICK_BIT]
			|| stat_ff[ptt_pkg::STAT_OVR_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("tick lost against a status clear");

	property p_irq_level;
		irq_ff == $past(|(stat_ff & mask_ff));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level does not follow status and mask");

	property p_no_tick_off;
		!en_ff |=> !tick;
	endproperty
	a_no_tick_off: assert property (p_no_tick_off)
		else $error("tick while the timer is disabled");

	property p_rate_held;
		en_ff |=> $stable(rate_ff);
	endproperty
	a_rate_held: assert property (p_rate_held)
		else $error("rate changed while the timer ran");

	property p_rate_read;
		req && !PWRITE && sel_ctrl |=> PRDATA[2:0] == $past(rate_ff);
	endproperty
	a_rate_read: assert property (p_rate_read)
		else $error("control read shows wrong rate");

endmodule

// ---- verification/test_ptt_top.sv ----
// Self-checking bench for the periodic tick timer: register table, refused
// accesses, tick period per rate code 3..7, early first tick and reset.
// Assumes ptt_pkg and ptt_top are compiled first; one 100 MHz clock.
`timescale 1ns/10ps

module test_ptt_top;
	// ------------------------------------------------------------
	// Signals and counters
	// ------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        err;
	} ptt_row_s;

	logic        CLK       = 1'b0;
	logic        RST       = 1'b1;
	logic        PSEL      = 1'b0;
	logic        PENABLE   = 1'b0;
	logic        PWRITE    = 1'b0;
	logic [11:0] PADDR     = 12'h000;
	logic [31:0] PWDATA    = 32'h00000000;
	logic [3:0]  PSTRB     = 4'hF;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        IRQ;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc       = 0;
	logic [31:0] rd;
	logic        er;
	int          t1;
	int          t2;
	int          t3;
	int          t_en;
	ptt_row_s    rows [15];
	int          sh [8]    = '{23, 21, 16, 14, 13, 12, 11, 9};

	ptt_top u_ptt_top (
		.CLK     (CLK),
		.RST     (RST),
		.PSEL    (PSEL),
		.PENABLE (PENABLE),
		.PWRITE  (PWRITE),
		.PADDR   (PADDR),
		.PWDATA  (PWDATA),
		.PSTRB   (PSTRB),
		.PRDATA  (PRDATA),
		.PREADY  (PREADY),
		.PSLVERR (PSLVERR),
		.IRQ     (IRQ)
	);

	// Clock and a cycle stamp used to measure tick spacing
	always #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		error_cnt++;
		$display("[FAIL] %0t timeout waiting for %s", $time, what);
		conclude();
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// One APB transfer; the request stands until PREADY is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			hang("bus answer");
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// Clear both status bits; IRQ is registered behind the status, so it
	// is low only from the second edge after the clearing write
	task automatic clr();
		apb(1'b1, ptt_pkg::OFS_STAT, 32'h00000003);
		repeat (2) @(posedge CLK);
		chk_bit(IRQ, 1'b0, "irq after clear");
	endtask

	// Bounded wait for IRQ; returns the cycle stamp at which it was seen
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (IRQ !== 1'b1 && n < 40000);
		if (IRQ !== 1'b1) begin
			hang("tick interrupt");
		end
		t = cyc;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rows[0]  = '{1'b0, ptt_pkg::OFS_CTRL, 32'h0, 32'h00, 1'b0};
		rows[1]  = '{1'b0, ptt_pkg::OFS_STAT, 32'h0, 32'h00, 1'b0};
		rows[2]  = '{1'b0, ptt_pkg::OFS_MASK, 32'h0, 32'h00, 1'b0};
		rows[3]  = '{1'b0, ptt_pkg::OFS_TCNT, 32'h0, 32'h00, 1'b0};
		rows[4]  = '{1'b1, 12'h020, 32'h1, 32'h00, 1'b1};
		rows[5]  = '{1'b0, 12'h020, 32'h0, 32'h00, 1'b1};
		rows[6]  = '{1'b1, ptt_pkg::OFS_TCNT, 32'h5, 32'h00, 1'b1};
		rows[7]  = '{1'b1, ptt_pkg::OFS_CTRL, 32'hF6, 32'h00, 1'b0};
		rows[8]  = '{1'b0, ptt_pkg::OFS_CTRL, 32'h0, 32'h06, 1'b0};
		rows[9]  = '{1'b1, ptt_pkg::OFS_CTRL, 32'h0F, 32'h00, 1'b0};
		rows[10] = '{1'b0, ptt_pkg::OFS_CTRL, 32'h0, 32'h0F, 1'b0};
		rows[11] = '{1'b1, ptt_pkg::OFS_CTRL, 32'h02, 32'h00, 1'b0};
		rows[12] = '{1'b0, ptt_pkg::OFS_CTRL, 32'h0, 32'h07, 1'b0};
		rows[13] = '{1'b1, ptt_pkg::OFS_MASK, 32'h1, 32'h00, 1'b0};
		rows[14] = '{1'b0, ptt_pkg::OFS_MASK, 32'h0, 32'h01, 1'b0};
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		// Table of plain register accesses
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].wdata);
			chk_bit(er, rows[i].err, "slave error");
			if (!rows[i].wr && !rows[i].err) begin
				chk_word(rd, rows[i].rdata, "read data");
			end
		end
		$display("test register table done");
		// Masked ticks pile up as tick plus overrun without raising IRQ
		apb(1'b1, ptt_pkg::OFS_MASK, 32'h0);
		clr();
		apb(1'b1, ptt_pkg::OFS_CTRL, 32'h0F);
		repeat (1100) @(posedge CLK);
		apb(1'b0, ptt_pkg::OFS_STAT, 32'h0);
		chk_word(rd, 32'h3, "two ticks seen");
		chk_bit(IRQ, 1'b0, "masked irq");
		apb(1'b1, ptt_pkg::OFS_MASK, 32'h1);
		repeat (2) @(posedge CLK);
		chk_bit(IRQ, 1'b1, "unmasked irq");
		$display("test mask and overrun done");
		// Tick spacing for each rate code short enough to run
		for (int c = 3; c < 8; c++) begin
			apb(1'b1, ptt_pkg::OFS_CTRL, 32'(c));
			apb(1'b1, ptt_pkg::OFS_CTRL, 32'(8 + c));
			clr();
			wait_irq(t1);
			clr();
			wait_irq(t2);
			chk_word(32'(t2 - t1), 32'(1 << sh[c]), "tick period");
		end
		$display("test tick periods done");
		// No tick while off; on re-enable the divider keeps its phase
		apb(1'b1, ptt_pkg::OFS_CTRL, 32'h07);
		clr();
		repeat (600) @(posedge CLK);
		apb(1'b0, ptt_pkg::OFS_STAT, 32'h0);
		chk_word(rd, 32'h0, "no tick while off");
		apb(1'b1, ptt_pkg::OFS_CTRL, 32'h0F);
		t_en = cyc;
		wait_irq(t3);
		chk_word(32'((t3 - t2) % 512), 32'h0, "divider phase kept");
		// Within one period of the enabling edge, plus the edge, tick, status
		// and IRQ register stages between a tap edge and IRQ being seen
		chk_bit(t3 - t_en < 516, 1'b1, "early first tick");
		$display("test early first tick done");
		// Reset in mid-run returns the registers to their reset values
		@(posedge CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		chk_bit(IRQ, 1'b0, "irq in reset");
		RST <= 1'b0;
		apb(1'b0, ptt_pkg::OFS_CTRL, 32'h0);
		chk_word(rd, 32'h0, "control after reset");
		apb(1'b0, ptt_pkg::OFS_TCNT, 32'h0);
		chk_word(rd, 32'h0, "count after reset");
		// A write without its low byte strobe must leave the control alone
		PSTRB <= 4'hE;
		apb(1'b1, ptt_pkg::OFS_CTRL, 32'h0F);
		PSTRB <= 4'hF;
		apb(1'b0, ptt_pkg::OFS_CTRL, 32'h0);
		chk_word(rd, 32'h0, "strobe-less write ignored");
		// Divider refuses writes and counts on through an enabling write;
		// each transfer takes four edges, so two transfers apart is eight
		apb(1'b1, ptt_pkg::OFS_DIV, 32'h0);
		chk_bit(er, 1'b1, "divider is read-only");
		apb(1'b0, ptt_pkg::OFS_DIV, 32'h0);
		t1 = int'(rd);
		apb(1'b1, ptt_pkg::OFS_CTRL, 32'h0F);
		apb(1'b0, ptt_pkg::OFS_DIV, 32'h0);
		chk_word(rd - 32'(t1), 32'h8, "divider undisturbed");
		$display("test reset done");
		conclude();
	end
endmodule
